/* File: rtl/shcd_decoder.sv */
// Operation
// - 100101TT takes four bytes, queues one message
// - Fast read streams registers upward from index
// - Fast write only lands in master control
// - 0x80 reads memory at pointer, increments
// - 0x84 writes memory at pointer, increments
// - 0x8C loads pointer, high byte first
// - 0x88 returns pointer, leaves it unchanged
// - FIFO read pops one byte per frame byte, with no length limit
// - Block read starts at vector's data block
// - Message read outputs label byte first
// - Bit six write, bits five-two index
// - Indices map to the listed status registers
// - Low two bits select transmit channel
// - One command per chip-select assertion
`timescale 1ns/1ps
`default_nettype none
`include "shcd_defines.svh"
module shcd_decoder
  import shcd_pkg::*;
#(
  parameter int TX_DEPTH = 2
)(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_si,
  output logic                      spi_so,
  output logic                      spi_so_oe_n,
  input  wire logic [7:0]           rx_pending_interrupt_summary,
  input  wire logic [63:0]          rx_interrupt_vectors,
  input  wire logic [7:0]           pending_interrupts,
  input  wire logic [7:0]           rx_fifo_flags,
  input  wire logic [7:0]           tx_buffer_status,
  input  wire logic [7:0]           master_status,
  output logic [7:0]                master_control,
  output shcd_pkg::shcd_mem_req_t   mem_req,
  input  wire logic [7:0]           mem_rdata,
  output shcd_pkg::shcd_rx_req_t    rx_req,
  input  wire logic [7:0]           rx_byte,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output shcd_pkg::shcd_tx_msg_t    tx_msg,
  output logic                      tx_overflow
);
  import shcd_pkg::*;

  // The buffer logic below serves exactly two entries.
  if (TX_DEPTH != 2)
  begin : g_depth_check
    $error("TX_DEPTH must be 2.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State record; every flip-flop of the block lives here.
  typedef struct packed {
    logic [1:0]       cs_s;       // Chip select synchroniser.
    logic [1:0]       sck_s;      // Serial clock synchroniser.
    logic [1:0]       si_s;       // Serial data synchroniser.
    logic             sck_d;      // Previous synchronised clock.
    shcd_state_t      st;         // Frame phase.
    shcd_cmd_t        cmd;        // Decoded command.
    logic [2:0]       bitcnt;     // Bits received in this byte.
    logic [7:0]       sh_in;      // Incoming shift register.
    logic [7:0]       sh_out;     // Outgoing shift register.
    logic [7:0]       data_cnt;   // Data bytes finished in this frame.
    logic [3:0]       idx;        // Fast-access register index.
    logic [1:0]       tx_ch;      // Transmit channel.
    logic [2:0]       rx_ch;      // Receive channel.
    logic [15:0]      ptr;        // Memory address pointer.
    logic [31:0]      tx_asm;     // Message being assembled.
    logic [7:0]       mctrl;      // Master control register.
    logic             so;         // Serial output bit.
    logic             oe_n;       // Serial output enable, low drives.
    logic [1:0]       buf_v;      // Transmit buffer valid flags.
    shcd_tx_msg_t [1:0] buf_d;    // Transmit buffer entries.
    logic             ovf;        // Message dropped for lack of room.
    shcd_mem_req_t    mreq;       // Memory request.
    shcd_rx_req_t     rreq;       // Receive fetch request.
  } shcd_regs_t;

  shcd_regs_t s_r;    // Registered state.
  shcd_regs_t s_nxt;  // Next state.

  ////////////////////////////////////////////////////////////////////////////////
  // Decodes a command byte into its operation.
  function automatic shcd_cmd_t decode(input logic [7:0] b);
    shcd_cmd_t c;
    c = SHCD_CMD_BAD;
    if ((b & `SHCD_OP_FAST_MASK) == 8'h00)
      c = b[`SHCD_FAST_WR_BIT] ? SHCD_CMD_FAST_WR : SHCD_CMD_FAST_RD;
    else if (b == `SHCD_OP_MEM_RD)
      c = SHCD_CMD_MEM_RD;
    else if (b == `SHCD_OP_MEM_WR)
      c = SHCD_CMD_MEM_WR;
    else if (b == `SHCD_OP_PTR_RD)
      c = SHCD_CMD_PTR_RD;
    else if (b == `SHCD_OP_PTR_WR)
      c = SHCD_CMD_PTR_WR;
    else if ((b & `SHCD_OP_TX_MASK) == `SHCD_OP_TX_BASE)
      c = SHCD_CMD_TX;
    else if ((b & `SHCD_OP_RX_MASK) == `SHCD_OP_FIFO_BASE)
      c = SHCD_CMD_FIFO;
    else if ((b & `SHCD_OP_RX_MASK) == `SHCD_OP_BLK_BASE)
      c = SHCD_CMD_BLK;
    else if ((b & `SHCD_OP_RX_MASK) == `SHCD_OP_MSG_BASE)
      c = SHCD_CMD_MSG;
    return c;
  endfunction

  // Returns the fast-access register selected by an index.
  function automatic logic [7:0] reg_read(input logic [3:0] i, input logic [7:0] mc);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      `SHCD_IDX_SUMMARY: v = rx_pending_interrupt_summary;
      `SHCD_IDX_PEND:    v = pending_interrupts;
      `SHCD_IDX_FIFOFLG: v = rx_fifo_flags;
      `SHCD_IDX_TXSTAT:  v = tx_buffer_status;
      `SHCD_IDX_MSTAT:   v = master_status;
      `SHCD_IDX_MCTRL:   v = mc;
      `SHCD_IDX_RSVD9, `SHCD_IDX_RSVD11: v = 8'h00;
      default:           v = rx_interrupt_vectors[(i - 4'h1) * 8 +: 8];
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Frame handling, decoding and buffer update.
  logic sck_rise;   // Rising serial clock edge seen.
  logic sck_fall;   // Falling serial clock edge seen.
  logic byte_done;  // A full byte just arrived.
  logic [7:0] rbyte;  // The byte just completed.
  logic [7:0] next_out;  // Byte to shift out next.
  logic push;       // Completed message to buffer.
  logic pop;        // Receiver took the head entry.

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cs_s = {s_r.cs_s[0], spi_cs_n};
    s_nxt.sck_s = {s_r.sck_s[0], spi_sck};
    s_nxt.si_s = {s_r.si_s[0], spi_si};
    s_nxt.sck_d = s_r.sck_s[1];
    s_nxt.mreq.rd = 1'b0;
    s_nxt.mreq.wr = 1'b0;
    s_nxt.rreq.fifo_pop = 1'b0;
    s_nxt.rreq.vec_load = 1'b0;
    sck_rise = s_r.sck_s[1] & ~s_r.sck_d;
    sck_fall = ~s_r.sck_s[1] & s_r.sck_d;
    rbyte = {s_r.sh_in[6:0], s_r.si_s[1]};
    byte_done = sck_rise & ~s_r.cs_s[1] & (s_r.bitcnt == 3'h7);
    next_out = 8'h00;
    push = 1'b0;
    pop = tx_valid & tx_ready;
    // Chip select high ends the frame and drops partial bytes.
    if (s_r.cs_s[1])
    begin
      s_nxt.st = SHCD_ST_CMD;
      s_nxt.bitcnt = 3'h0;
      s_nxt.data_cnt = 8'h00;
      s_nxt.oe_n = 1'b1;
      s_nxt.so = 1'b0;
    end
    else
    begin
      s_nxt.oe_n = 1'b0;
      if (sck_rise)
      begin
        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
        s_nxt.sh_in = rbyte;
      end
      if (sck_fall)
      begin
        s_nxt.so = s_r.sh_out[7];
        s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
      end
    end
    // Byte boundary: decode a command or act on a data byte.
    if (byte_done)
    begin
      case (s_r.st)
        SHCD_ST_CMD:
        begin
          s_nxt.cmd = decode(rbyte);
          s_nxt.idx = rbyte[`SHCD_IDX_MSB:`SHCD_IDX_LSB];
          s_nxt.tx_ch = rbyte[1:0];
          s_nxt.rx_ch = rbyte[4:2];
          s_nxt.st = (decode(rbyte) == SHCD_CMD_BAD) ? SHCD_ST_DONE : SHCD_ST_DATA;
          case (decode(rbyte))
            SHCD_CMD_FAST_RD: next_out = reg_read(rbyte[5:2], s_r.mctrl);
            SHCD_CMD_MEM_RD: next_out = mem_rdata;
            SHCD_CMD_PTR_RD: next_out = s_r.ptr[15:8];
            SHCD_CMD_FIFO:
            begin
              s_nxt.rreq.fifo_pop = 1'b1;
              next_out = rx_byte;
            end
            SHCD_CMD_BLK, SHCD_CMD_MSG:
            begin
              s_nxt.rreq.vec_load = 1'b1;
              next_out = rx_byte;
            end
            default: next_out = 8'h00;
          endcase
          s_nxt.sh_out = next_out;
        end
        SHCD_ST_DATA:
        begin
          s_nxt.data_cnt = s_r.data_cnt + 8'h01;
          case (s_r.cmd)
            SHCD_CMD_FAST_RD:
            begin
              s_nxt.idx = s_r.idx + 4'h1;
              s_nxt.sh_out = reg_read(s_r.idx + 4'h1, s_r.mctrl);
            end
            SHCD_CMD_FAST_WR:
            begin
              if (s_r.idx == `SHCD_IDX_MCTRL)
                s_nxt.mctrl = rbyte;
              s_nxt.idx = s_r.idx + 4'h1;
            end
            SHCD_CMD_MEM_RD:
            begin
              s_nxt.ptr = s_r.ptr + 16'h0001;
              s_nxt.mreq.rd = 1'b1;
            end
            SHCD_CMD_MEM_WR:
            begin
              s_nxt.mreq.wr = 1'b1;
              s_nxt.mreq.wdata = rbyte;
              s_nxt.ptr = s_r.ptr + 16'h0001;
            end
            SHCD_CMD_PTR_RD:
            begin
              s_nxt.sh_out = s_r.ptr[7:0];
              if (s_r.data_cnt == 8'h01)
                s_nxt.st = SHCD_ST_DONE;
            end
            SHCD_CMD_PTR_WR:
            begin
              if (s_r.data_cnt == 8'h00)
                s_nxt.ptr[15:8] = rbyte;
              else
              begin
                s_nxt.ptr[7:0] = rbyte;
                s_nxt.st = SHCD_ST_DONE;
              end
            end
            SHCD_CMD_TX:
            begin
              s_nxt.tx_asm = {s_r.tx_asm[23:0], rbyte};
              if (s_r.data_cnt == 8'h03)
              begin
                push = 1'b1;
                s_nxt.st = SHCD_ST_DONE;
              end
            end
            SHCD_CMD_FIFO:
            begin
              s_nxt.rreq.fifo_pop = 1'b1;
              s_nxt.sh_out = rx_byte;
            end
            SHCD_CMD_BLK, SHCD_CMD_MSG:
            begin
              s_nxt.rreq.vec_load = 1'b0;
              s_nxt.sh_out = rx_byte;
              if (s_r.data_cnt == 8'h03)
                s_nxt.st = SHCD_ST_DONE;
            end
            default: s_nxt.st = SHCD_ST_DONE;
          endcase
        end
        SHCD_ST_DONE: s_nxt.st = SHCD_ST_DONE;
        default: s_nxt.st = SHCD_ST_DONE;
      endcase
    end
    s_nxt.rreq.chan = s_nxt.rx_ch;
    s_nxt.mreq.addr = s_nxt.ptr;
    // Read data for the moved pointer stands in the same cycle as the pulse.
    if (s_r.mreq.rd)
      s_nxt.sh_out = mem_rdata;
    // Two-entry buffer: pop shifts, push fills the first free slot.
    if (pop)
    begin
      s_nxt.buf_d[0] = s_r.buf_d[1];
      s_nxt.buf_v = {1'b0, s_r.buf_v[1]};
    end
    if (push)
    begin
      if (!s_nxt.buf_v[0])
      begin
        s_nxt.buf_v[0] = 1'b1;
        s_nxt.buf_d[0] = '{chan: s_r.tx_ch, word: {s_r.tx_asm[23:0], rbyte}};
      end
      else if (!s_nxt.buf_v[1])
      begin
        s_nxt.buf_v[1] = 1'b1;
        s_nxt.buf_d[1] = '{chan: s_r.tx_ch, word: {s_r.tx_asm[23:0], rbyte}};
      end
      else
        s_nxt.ovf = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset gives idle frame and empty buffer.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.cs_s <= 2'b11;
      s_r.oe_n <= 1'b1;
      s_r.mctrl <= `SHCD_MCTRL_RESET;
      s_r.ptr <= `SHCD_PTR_RESET;
      s_r.st <= SHCD_ST_CMD;
      s_r.cmd <= SHCD_CMD_NONE;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign spi_so = s_r.so;
  assign spi_so_oe_n = s_r.oe_n;
  assign master_control = s_r.mctrl;
  assign mem_req = s_r.mreq;
  assign rx_req = s_r.rreq;
  assign tx_valid = s_r.buf_v[0];
  assign tx_msg = s_r.buf_d[0];
  assign tx_overflow = s_r.ovf;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_tx_push_len: assert property (@(posedge mclk) disable iff (!resetn)
    (byte_done && s_r.st == SHCD_ST_DATA && s_r.cmd == SHCD_CMD_TX) |->
      (push == (s_r.data_cnt == 8'h03)))
    else $error("Transmit message not queued on the fourth byte.");
  chk_fast_rd_inc: assert property (@(posedge mclk) disable iff (!resetn)
    (byte_done && s_r.st == SHCD_ST_DATA && s_r.cmd == SHCD_CMD_FAST_RD) |=>
      (s_r.idx == $past(s_r.idx) + 4'h1))
    else $error("Fast read index did not advance.");
  chk_mctrl_only: assert property (@(posedge mclk) disable iff (!resetn)
    (s_r.mctrl != $past(s_r.mctrl)) |->
      ($past(s_r.cmd) == SHCD_CMD_FAST_WR && $past(s_r.idx) == `SHCD_IDX_MCTRL))
    else $error("Master control changed outside its write.");
  chk_mem_rd_inc: assert property (@(posedge mclk) disable iff (!resetn)
    (byte_done && s_r.st == SHCD_ST_DATA && s_r.cmd == SHCD_CMD_MEM_RD) |=>
      (s_r.ptr == $past(s_r.ptr) + 16'h0001))
    else $error("Pointer did not advance after memory read.");
  chk_mem_wr_strobe: assert property (@(posedge mclk) disable iff (!resetn)
    mem_req.wr |-> ($past(s_r.cmd) == SHCD_CMD_MEM_WR && mem_req.addr == $past(s_r.ptr) + 16'h0001))
    else $error("Memory write strobe without write command.");
  chk_ptr_load: assert property (@(posedge mclk) disable iff (!resetn)
    (byte_done && s_r.st == SHCD_ST_DATA && s_r.cmd == SHCD_CMD_PTR_WR && s_r.data_cnt == 8'h00)
      |=> (s_r.ptr[15:8] == $past(rbyte)))
    else $error("Pointer high byte not loaded first.");
  chk_ptr_read_keep: assert property (@(posedge mclk) disable iff (!resetn)
    (s_r.cmd == SHCD_CMD_PTR_RD && s_r.st != SHCD_ST_CMD) |=> $stable(s_r.ptr))
    else $error("Pointer changed during pointer read.");
  chk_bad_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (s_r.cmd == SHCD_CMD_BAD && s_r.st == SHCD_ST_DONE) |=>
      (!mem_req.wr && $stable(s_r.mctrl)))
    else $error("Undefined command had an effect.");
  chk_one_cmd: assert property (@(posedge mclk) disable iff (!resetn)
    (s_r.st == SHCD_ST_DONE && !s_r.cs_s[1]) |=> (s_r.st == SHCD_ST_DONE))
    else $error("Second command accepted within one select.");
endmodule
`default_nettype wire

/* File: shared/shcd_defines.svh */
`ifndef SHCD_DEFINES_SVH
`define SHCD_DEFINES_SVH
// Command opcodes and masks.
`define SHCD_OP_MEM_RD      8'h80
`define SHCD_OP_MEM_WR      8'h84
`define SHCD_OP_PTR_RD      8'h88
`define SHCD_OP_PTR_WR      8'h8C
`define SHCD_OP_TX_BASE     8'h94
`define SHCD_OP_TX_MASK     8'hFC
`define SHCD_OP_FAST_MASK   8'h83
`define SHCD_OP_RX_MASK     8'hE3
`define SHCD_OP_FIFO_BASE   8'hA0
`define SHCD_OP_BLK_BASE    8'hC0
`define SHCD_OP_MSG_BASE    8'hE0
// Fast-access command fields.
`define SHCD_FAST_WR_BIT    6
`define SHCD_IDX_MSB        5
`define SHCD_IDX_LSB        2
// Register indices.
`define SHCD_IDX_SUMMARY    4'h0
`define SHCD_IDX_VEC0       4'h1
`define SHCD_IDX_VEC7       4'h8
`define SHCD_IDX_RSVD9      4'h9
`define SHCD_IDX_PEND       4'hA
`define SHCD_IDX_RSVD11     4'hB
`define SHCD_IDX_FIFOFLG    4'hC
`define SHCD_IDX_TXSTAT     4'hD
`define SHCD_IDX_MSTAT      4'hE
`define SHCD_IDX_MCTRL      4'hF
// Reset values and sizes.
`define SHCD_MCTRL_RESET    8'h00
`define SHCD_PTR_RESET      16'h0000
`define SHCD_TX_MSG_BYTES   3'h4
`define SHCD_PTR_BYTES      3'h2
`define SHCD_RX_MSG_BYTES   3'h4
`endif

/* File: shared/shcd_pkg.sv */
`default_nettype none
package shcd_pkg;
  // Command decoded from the first byte of a frame.
  typedef enum logic [3:0] {
    SHCD_CMD_NONE,
    SHCD_CMD_FAST_RD,
    SHCD_CMD_FAST_WR,
    SHCD_CMD_MEM_RD,
    SHCD_CMD_MEM_WR,
    SHCD_CMD_PTR_RD,
    SHCD_CMD_PTR_WR,
    SHCD_CMD_TX,
    SHCD_CMD_FIFO,
    SHCD_CMD_BLK,
    SHCD_CMD_MSG,
    SHCD_CMD_BAD
  } shcd_cmd_t;

  // Frame phase, Gray coded along command, data, done.
  typedef enum logic [1:0] {
    SHCD_ST_CMD  = 2'b00,
    SHCD_ST_DATA = 2'b01,
    SHCD_ST_DONE = 2'b11
  } shcd_state_t;

  // Memory-side request from the decoder.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } shcd_mem_req_t;

  // Transmit message word with its channel.
  typedef struct packed {
    logic [1:0]  chan;
    logic [31:0] word;
  } shcd_tx_msg_t;

  // Receive-side fetch request.
  typedef struct packed {
    logic       fifo_pop;
    logic       vec_load;
    logic [2:0] chan;
  } shcd_rx_req_t;
endpackage
`default_nettype wire

/* File: verification/shcd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host-side serial master, mode 0: data changes with SCK low, sampled on rise.
module shcd_host_model
  import shcd_pkg::*;
(
  input  wire logic mclk,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  import shcd_pkg::*;
  localparam int HALF = 20;  // Half of the 160 ns serial period in mclk cycles.
  logic [7:0]    tx_buf [16]; // Bytes sent in a frame, command first.
  logic [7:0]    rx_buf [16]; // Bytes heard back, one per byte sent.

  // Idle pins: deselected, clock parked low between frames.
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // One frame of n whole bytes, MSB first; the clock stands still outside it.
  task automatic frame(input int n);
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int b = 0; b < n; b++)
      for (int i = 7; i >= 0; i--)
      begin
        si <= tx_buf[b][i];
        repeat (HALF) @(posedge mclk);
        rx_buf[b][i] = so;
        sck <= 1'b1;
        repeat (HALF) @(posedge mclk);
        sck <= 1'b0;
      end
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: verification/test_spi_host_command_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shcd_defines.svh"
module test_spi_host_command_decoder;
  import shcd_pkg::*;
  localparam int LIMIT = 95000; // Cycle ceiling for the whole run.
  logic          mclk, resetn, spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n;
  logic          so_last, so_line, tx_valid, tx_ready, tx_overflow;
  logic [7:0]    rx_pending_interrupt_summary, pending_interrupts, rx_fifo_flags;
  logic [7:0]    tx_buffer_status, master_status, master_control, mem_rdata;
  logic [7:0]    rx_byte, mc_exp;
  logic [63:0]   rx_interrupt_vectors;
  logic [7:0]    mem [256]; // Memory behind the pointer.
  logic [2:0]    rx_last;   // Channel of the latest receive request.
  shcd_mem_req_t mem_req;
  shcd_rx_req_t  rx_req;
  shcd_tx_msg_t  tx_msg;
  shcd_tx_msg_t  txq [$];   // Messages taken by the transmit side.
  int            fail_count, n_compared, cyc, pop_n, load_n, rd_n;

  shcd_decoder dut (
    .mclk, .resetn, .spi_cs_n, .spi_sck, .spi_si, .spi_so, .spi_so_oe_n,
    .rx_pending_interrupt_summary, .rx_interrupt_vectors, .pending_interrupts,
    .rx_fifo_flags, .tx_buffer_status, .master_status, .master_control,
    .mem_req, .mem_rdata, .rx_req, .rx_byte, .tx_valid, .tx_ready, .tx_msg,
    .tx_overflow
  );
  shcd_host_model host (
    .mclk(mclk), .cs_n(spi_cs_n), .sck(spi_sck), .si(spi_si), .so(so_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // A released output line shows the inverse of its last level, not a stale copy.
  assign so_line = spi_so_oe_n ? ~so_last : spi_so;
  assign mem_rdata = mem[mem_req.addr[7:0]];

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Memory, receive and transmit partners, plus the hang guard.
  always @(posedge mclk)
  begin
    cyc++;
    if (!spi_so_oe_n)
      so_last <= spi_so;
    if (mem_req.wr === 1'b1)
      mem[mem_req.addr[7:0] - 8'h01] <= mem_req.wdata;
    if (mem_req.rd === 1'b1)
      rd_n++;
    if (rx_req.fifo_pop === 1'b1)
      pop_n++;
    if (rx_req.vec_load === 1'b1)
      load_n++;
    if ((rx_req.fifo_pop | rx_req.vec_load) === 1'b1)
      rx_last = rx_req.chan;
    if ((tx_valid & tx_ready) === 1'b1)
      txq.push_back(tx_msg);
    if (cyc == LIMIT)
    begin
      fail_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status pattern for register index k; p flips every bit for a second pass.
  function automatic logic [7:0] pat(input int k, input logic p);
    return {k[3:0], ~k[3:0]} ^ {8{p}};
  endfunction

  // Expected fast-read value: reserved slots read zero.
  function automatic logic [7:0] exp_reg(input int k, input logic p);
    if (k == 9 || k == 11)
      return 8'h00;
    if (k == 15)
      return mc_exp;
    return pat(k, p);
  endfunction

  task automatic set_regs(input logic p);
    rx_pending_interrupt_summary <= pat(0, p);
    for (int n = 0; n < 8; n++)
      rx_interrupt_vectors[8*n +: 8] <= pat(n + 1, p);
    pending_interrupts <= pat(10, p);
    rx_fifo_flags <= pat(12, p);
    tx_buffer_status <= pat(13, p);
    master_status <= pat(14, p);
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  // Sends the first n of five bytes, leftmost first.
  task automatic send(input int n, input logic [39:0] bytes);
    for (int i = 0; i < n; i++)
      host.tx_buf[i] = bytes[39 - 8*i -: 8];
    host.frame(n);
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn <= 1'b0;
    tx_ready <= 1'b1;
    rx_byte <= 8'h00;
    so_last <= 1'b0;
    mc_exp = `SHCD_MCTRL_RESET;
    set_regs(1'b0);
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    check(master_control, `SHCD_MCTRL_RESET);
    check(spi_so_oe_n, 1'b1);
    // Every fast-read index, with two status patterns.
    for (int p = 0; p < 2; p++)
    begin
      @(posedge mclk);
      set_regs(p[0]);
      for (int k = 0; k < 16; k++)
      begin
        send(2, {2'b00, k[3:0], 2'b00, 32'h0});
        check(host.rx_buf[1], exp_reg(k, p[0]));
      end
    end
    // Only master control takes writes; junk commands change nothing.
    send(2, {8'h7C, 8'h5A, 24'h0});
    mc_exp = 8'h5A;
    check(master_control, mc_exp);
    send(3, {8'h78, 8'h11, 8'h22, 16'h0});
    mc_exp = 8'h22;
    check(master_control, mc_exp);
    send(2, {8'h40, 8'h99, 24'h0});
    check(master_control, mc_exp);
    send(2, {8'h7D, 8'h77, 24'h0});
    check(master_control, mc_exp);
    send(4, {8'h38, 32'h0});
    check(host.rx_buf[1], pat(14, 1'b1));
    check(host.rx_buf[2], mc_exp);
    check(host.rx_buf[3], pat(0, 1'b1));
    // Pointer load, read back, then memory write and read through it.
    send(3, {8'h8C, 16'h0010, 16'h0});
    send(3, {8'h88, 32'h0});
    check({host.rx_buf[1], host.rx_buf[2]}, 16'h0010);
    send(4, {8'h84, 24'hA1B2C3, 8'h00});
    send(3, {8'h8C, 16'h0010, 16'h0});
    rd_n = 0;
    send(4, {8'h80, 32'h0});
    check({host.rx_buf[1], host.rx_buf[2], host.rx_buf[3]}, 24'hA1B2C3);
    check(rd_n[2:0], 3'h3);
    send(3, {8'h88, 32'h0});
    check({host.rx_buf[1], host.rx_buf[2]}, 16'h0013);
    // Receive fetches: FIFO, block and message for every channel.
    for (int op = 0; op < 3; op++)
      for (int c = 0; c < 8; c++)
      begin
        int n;
        n = (op == 0) ? 5 : 2;
        @(posedge mclk);
        rx_byte <= {c[2:0], 5'h15};
        pop_n = 0;
        load_n = 0;
        send(n, {3'(op + 5), c[2:0], 2'b00, 32'h0});
        for (int i = 1; i < n; i++)
          check(host.rx_buf[i], {c[2:0], 5'h15});
        check(rx_last, c[2:0]);
        check({pop_n > 0, load_n[1:0]}, (op == 0) ? 3'h4 : 3'h1);
      end
    // Transmit: stall until the buffer refuses, then drain and send more.
    @(posedge mclk);
    tx_ready <= 1'b0;
    send(5, {8'h94, 32'h01020304});
    send(5, {8'h95, 32'h11121314});
    check(tx_overflow, 1'b0);
    send(5, {8'h96, 32'hDEADBEEF});
    check(tx_overflow, 1'b1);
    check(txq.size(), 34'h0);
    @(posedge mclk);
    tx_ready <= 1'b1;
    send(5, {8'h96, 32'h21222324});
    send(5, {8'h97, 32'h31323334});
    check(txq.size(), 34'h4);
    for (int t = 0; t < 4; t++)
      check(txq[t], {t[1:0], 32'h01020304 + 32'h10101010 * t});
    give_verdict();
  end
endmodule
`default_nettype wire
